//--- verilog/dmr_pkg.sv
/*
 * Constants, register map, field layout, reset values and enumerations of
 * the display mode and reset configuration block.
 * Assumes a 10 MHz system clock and a 32-bit APB register bus.
 */
package dmr_pkg;
	// Register indices; the byte address is four times the index
	localparam int REG_STORE = 24;
	localparam logic [5:0] IDX_OSC = 6'h00;
	localparam logic [5:0] IDX_DRV = 6'h01;
	localparam logic [5:0] IDX_AC = 6'h02;
	localparam logic [5:0] IDX_ENTRY = 6'h03;
	localparam logic [5:0] IDX_DISP1 = 6'h04;
	localparam logic [5:0] IDX_DISP2 = 6'h05;
	localparam logic [5:0] IDX_FRAME = 6'h06;
	localparam logic [5:0] IDX_EXT = 6'h07;
	localparam logic [5:0] IDX_PWR1 = 6'h08;
	localparam logic [5:0] IDX_PWR2 = 6'h09;
	localparam logic [5:0] IDX_PWR3 = 6'h0a;
	localparam logic [5:0] IDX_PWR4 = 6'h0b;
	localparam logic [5:0] IDX_RAM_ADDR = 6'h0c;
	localparam logic [5:0] IDX_RAM_DATA = 6'h0d;
	localparam logic [5:0] IDX_GAMMA0 = 6'h0e;
	localparam logic [5:0] IDX_GATE_START = 6'h12;
	localparam logic [5:0] IDX_SCROLL = 6'h13;
	localparam logic [5:0] IDX_SCR1 = 6'h14;
	localparam logic [5:0] IDX_SCR2 = 6'h15;
	localparam logic [5:0] IDX_WIN_H = 6'h16;
	localparam logic [5:0] IDX_WIN_V = 6'h17;
	localparam logic [5:0] IDX_STATUS = 6'h18;

	// Field positions
	localparam int F_OSC_RUN = 0;
	localparam int F_LINE_COUNT = 0;
	localparam int F_PIXCLK_EDGE = 12;
	localparam int F_ENABLE_POL = 13;
	localparam int F_VSYNC_POL = 15;
	localparam int F_INTERLACE = 0;
	localparam int F_ADDR_STEP = 4;
	localparam int F_DISP_ON = 0;
	localparam int F_BP = 0;
	localparam int F_FP = 8;
	localparam int F_RTN = 0;
	localparam int F_DM = 4;
	localparam int F_RM = 8;
	localparam int F_BOOST_FREQ = 4;
	localparam int F_START = 0;
	localparam int F_END = 16;
	localparam int ST_IM = 0;
	localparam int ST_BUS = 4;
	localparam int ST_RGB = 8;
	localparam int ST_FSYNC = 9;
	localparam int ST_BAD = 10;
	localparam int ST_SETTLED = 11;

	// Field reset values
	localparam logic RST_OSC_RUN = 1'b1;
	localparam logic [5:0] RST_LINE_COUNT = 6'h27;
	localparam logic [1:0] RST_INTERLACE = 2'h1;
	localparam logic [1:0] RST_ADDR_STEP = 2'h3;
	localparam logic [3:0] RST_PORCH = 4'h8;
	localparam logic [2:0] RST_BOOST_FREQ = 3'h3;
	localparam logic [8:0] RST_SCREEN_END = 9'h13f;
	localparam logic [8:0] RST_WIN_H_END = 9'h1df;
	localparam logic [8:0] RST_WIN_V_END = 9'h13f;

	localparam logic [31:0] REG_MASK [REG_STORE] = '{
		32'h0000_0001, 32'h0000_f33f, 32'h0000_0303, 32'h0000_d030,
		32'h0000_372f, 32'h0000_0f0f, 32'h0000_f33f, 32'h0000_0133,
		32'h0000_7773, 32'h0000_3f07, 32'h0000_0007, 32'h0000_bf3f,
		32'h0001_ffff, 32'h0000_0000, 32'h0000_ffff, 32'h0000_ffff,
		32'h0000_ffff, 32'h0000_ffff, 32'h0000_003f, 32'h0000_01ff,
		32'h01ff_01ff, 32'h01ff_00ff, 32'h01ff_01ff, 32'h01ff_01ff};

	localparam logic [31:0] REG_RST [REG_STORE] = '{
		{31'h0, RST_OSC_RUN}, {26'h0, RST_LINE_COUNT},
		{30'h0, RST_INTERLACE}, {26'h0, RST_ADDR_STEP, 4'h0},
		32'h0, {20'h0, RST_PORCH, 4'h0, RST_PORCH}, 32'h0, 32'h0,
		{25'h0, RST_BOOST_FREQ, 4'h0}, 32'h0, 32'h0, 32'h0,
		32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
		{7'h0, RST_SCREEN_END, 16'h0}, {7'h0, RST_SCREEN_END, 16'h0},
		{7'h0, RST_WIN_H_END, 16'h0}, {7'h0, RST_WIN_V_END, 16'h0}};

	// Timing
	localparam int CLK_HZ = 10_000_000;
	localparam int OSC_SETTLE_MS = 10;
	localparam int OSC_SETTLE_CYC = CLK_HZ / 1000 * OSC_SETTLE_MS;
	localparam logic [4:0] LINE_BASE_CLKS = 5'h10;

	typedef enum logic [2:0] {
		BUS_P16 = 3'b000,
		BUS_P8 = 3'b001,
		BUS_P18 = 3'b010,
		BUS_P9 = 3'b011,
		BUS_SPI = 3'b100,
		BUS_PKT = 3'b101,
		BUS_OFF = 3'b110
	} dmr_bus_t;

	typedef enum logic [1:0] {
		MODE_INT = 2'b00,
		MODE_RGB = 2'b01,
		MODE_FSYNC = 2'b10,
		MODE_BAD = 2'b11
	} dmr_mode_t;
endpackage

//--- verilog/dmr_top.sv
/*
 * Display mode and reset configuration: instruction register bank with
 * reset defaults, host bus decode, display mode decode, scan timing and
 * frame memory write path (system bus or RGB pixel port).
 * Assumes an APB master on mclk and pixel port inputs synchronous to mclk.
 */
// Overview of operation
// - Reset sets the oscillator run control to one.
// - Reset loads line count 100111, scan directions and polarities zero.
// - Reset loads interlace 01, line inversion and alternation zero.
// - Reset loads address step 11, other entry bits zero.
// - Reset clears every display control 1 field; display off.
// - Reset loads both porch line counts with 1000.
// - Reset clears frame cycle fields; clocks per line 0000 means 16.
// - Reset selects 18-bit RGB, internal clock, system write path.
// - Reset clears power fields except boost frequency 011.
// - Reset loads frame memory address counter with zero.
// - Reset clears gamma, gate start row and scroll amount.
// - Reset loads screen ends 100111111 and screen starts zero.
// - Reset sets write window to full frame.
// - Reset leaves frame memory alone; host clears it with display off.
// - Instruction registers other than the address counter are written only through the system bus.
// - Timing source 00 internal, 01 RGB, 10 frame sync; path bit.
// - RGB mode and frame sync mode never run together.
// - RGB mode captures pixels only while data enable is active.
// - Frame sync mode restarts scanning at each sync falling edge.
// - Four mode pins select parallel, serial or packet host bus.
module dmr_top
	import dmr_pkg::*;
#(
	parameter int SETTLE_CYCLES = dmr_pkg::OSC_SETTLE_CYC
) (
	input wire logic mclk, // System clock
	input wire logic srst, // Synchronous reset
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic [3:0] host_if_select, // Host bus mode pins
	input wire logic rgb_vsync, // Pixel port frame sync
	input wire logic rgb_dotclk, // Pixel port clock
	input wire logic rgb_enable, // Pixel port data enable
	input wire logic [17:0] rgb_data, // Pixel port data
	output logic fm_we, // Frame memory write strobe
	output logic [16:0] fm_addr, // Frame memory address
	output logic [17:0] fm_wdata, // Frame memory data
	output dmr_pkg::dmr_bus_t host_bus_type, // Decoded host bus
	output logic host_bus_80, // Parallel bus is 80-style
	output dmr_pkg::dmr_mode_t disp_mode, // Active display mode
	output logic [9:0] scan_line, // Current scan line
	output logic scan_frame_start, // First line of a frame
	output logic osc_run, // Oscillator run control
	output logic osc_settled // Oscillator settle time elapsed
);
	import dmr_pkg::*;

	typedef struct packed {
		logic [REG_STORE-1:0][31:0] regs;
		logic [3:0] im;
		dmr_bus_t bus;
		dmr_mode_t mode;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic fm_we;
		logic [16:0] fm_addr;
		logic [17:0] fm_wdata;
		logic vs_q;
		logic dclk_q;
		logic [4:0] line_clk;
		logic [9:0] scan_line;
		logic frame_start;
		logic [16:0] settle_cnt;
		logic settled;
	} dmr_state_t;

	dmr_state_t st_r;
	dmr_state_t st_nxt;

	function automatic dmr_bus_t dmr_decode(input logic [3:0] im);
		case (im)
			4'b0000, 4'b0010: dmr_decode = BUS_P16;
			4'b0001, 4'b0011: dmr_decode = BUS_P8;
			4'b0100, 4'b0101: dmr_decode = BUS_SPI;
			4'b1000, 4'b1010: dmr_decode = BUS_P18;
			4'b1001, 4'b1011: dmr_decode = BUS_P9;
			4'b1100, 4'b1101: dmr_decode = BUS_PKT;
			default: dmr_decode = BUS_OFF;
		endcase
	endfunction

	// Field views
	logic [5:0] line_count;
	logic pixclk_edge_sel;
	logic enable_polarity;
	logic vsync_polarity;
	logic addr_step_dir0;
	logic [3:0] front_porch_lines;
	logic [3:0] back_porch_lines;
	logic [3:0] clocks_per_line;
	logic [1:0] display_timing_src;
	logic ram_write_path;
	logic [16:0] ram_addr_counter;
	logic [16:0] win_origin;
	logic [5:0] idx;
	logic addr_ok;
	logic vs_active_edge;
	logic vs_fall;
	logic dclk_edge;
	logic pix_take;
	logic [9:0] frame_last;
	logic [4:0] line_last;
	logic [16:0] addr_step;

	assign line_count = st_r.regs[IDX_DRV][F_LINE_COUNT +: 6];
	assign pixclk_edge_sel = st_r.regs[IDX_DRV][F_PIXCLK_EDGE];
	assign enable_polarity = st_r.regs[IDX_DRV][F_ENABLE_POL];
	assign vsync_polarity = st_r.regs[IDX_DRV][F_VSYNC_POL];
	assign addr_step_dir0 = st_r.regs[IDX_ENTRY][F_ADDR_STEP];
	assign front_porch_lines = st_r.regs[IDX_DISP2][F_FP +: 4];
	assign back_porch_lines = st_r.regs[IDX_DISP2][F_BP +: 4];
	assign clocks_per_line = st_r.regs[IDX_FRAME][F_RTN +: 4];
	assign display_timing_src = st_r.regs[IDX_EXT][F_DM +: 2];
	assign ram_write_path = st_r.regs[IDX_EXT][F_RM];
	assign ram_addr_counter = st_r.regs[IDX_RAM_ADDR][16:0];
	assign win_origin = {st_r.regs[IDX_WIN_V][F_START +: 9],
		st_r.regs[IDX_WIN_H][F_START +: 8]};
	assign idx = paddr[7:2];
	assign addr_ok = (paddr[1:0] == 2'h0) && (idx <= IDX_STATUS);
	assign addr_step = addr_step_dir0 ? 17'h00001 : 17'h1ffff;
	// Polarity bit zero: sync active low, enable active high
	assign vs_active_edge = vsync_polarity ? (!st_r.vs_q && rgb_vsync)
		: (st_r.vs_q && !rgb_vsync);
	assign vs_fall = st_r.vs_q && !rgb_vsync;
	assign dclk_edge = pixclk_edge_sel ? (st_r.dclk_q && !rgb_dotclk)
		: (!st_r.dclk_q && rgb_dotclk);
	assign pix_take = (st_r.mode == MODE_RGB) && dclk_edge
		&& (rgb_enable != enable_polarity);
	// Active rows in groups of eight plus porches
	assign frame_last = ({1'b0, line_count, 3'h0} + 10'h008)
		+ {6'h0, front_porch_lines} + {6'h0, back_porch_lines} - 10'h001;
	// Zero field gives the base of sixteen clocks
	assign line_last = LINE_BASE_CLKS + {1'b0, clocks_per_line}
		- 5'h01;

	always_comb begin
		logic [31:0] rdata;
		logic refuse;
		rdata = 32'h0;
		refuse = 1'b0;
		st_nxt = st_r;
		st_nxt.fm_we = 1'b0;
		st_nxt.frame_start = 1'b0;
		st_nxt.vs_q = rgb_vsync;
		st_nxt.dclk_q = rgb_dotclk;

		// Display mode decode
		case (display_timing_src)
			2'b00: st_nxt.mode = ram_write_path ? MODE_BAD : MODE_INT;
			2'b01: st_nxt.mode = ram_write_path ? MODE_RGB : MODE_BAD;
			2'b10: st_nxt.mode = ram_write_path ? MODE_BAD : MODE_FSYNC;
			default: st_nxt.mode = MODE_BAD;
		endcase

		// Oscillator settle timer
		if (!st_r.settled && st_r.regs[IDX_OSC][F_OSC_RUN]) begin
			st_nxt.settle_cnt = st_r.settle_cnt + 17'h00001;
			if (st_r.settle_cnt == 17'(SETTLE_CYCLES - 1)) begin
				st_nxt.settled = 1'b1;
			end
		end

		// Internal scan timing
		if (st_r.regs[IDX_OSC][F_OSC_RUN] && st_r.mode != MODE_BAD) begin
			if (st_r.line_clk >= line_last) begin
				st_nxt.line_clk = 5'h00;
				if (st_r.scan_line >= frame_last) begin
					st_nxt.scan_line = 10'h000;
					st_nxt.frame_start = 1'b1;
				end else begin
					st_nxt.scan_line = st_r.scan_line + 10'h001;
				end
			end else begin
				st_nxt.line_clk = st_r.line_clk + 5'h01;
			end
		end
		if ((st_r.mode == MODE_FSYNC && vs_fall)
			|| (st_r.mode == MODE_RGB && vs_active_edge)) begin
			st_nxt.line_clk = 5'h00;
			st_nxt.scan_line = 10'h000;
			st_nxt.frame_start = 1'b1;
			st_nxt.regs[IDX_RAM_ADDR] = {15'h0, win_origin};
		end else if (pix_take) begin
			// Pixel port writes memory and advances the address counter register
			st_nxt.fm_we = 1'b1;
			st_nxt.fm_addr = ram_addr_counter;
			st_nxt.fm_wdata = rgb_data;
			st_nxt.regs[IDX_RAM_ADDR] = {15'h0,
				ram_addr_counter + addr_step};
		end

		// APB slave: one wait state, then ready
		if (idx == IDX_STATUS) begin
			rdata[ST_IM +: 4] = st_r.im;
			rdata[ST_BUS +: 3] = st_r.bus;
			rdata[ST_RGB] = (st_r.mode == MODE_RGB);
			rdata[ST_FSYNC] = (st_r.mode == MODE_FSYNC);
			rdata[ST_BAD] = (st_r.mode == MODE_BAD);
			rdata[ST_SETTLED] = st_r.settled;
		end else if (addr_ok) begin
			rdata = st_r.regs[idx[4:0]];
		end
		refuse = !addr_ok || (pwrite && idx == IDX_STATUS)
			|| (pwrite && st_r.bus == BUS_OFF)
			|| (pwrite && idx == IDX_RAM_DATA && ram_write_path);
		if (st_r.pready) begin
			st_nxt.pready = 1'b0;
			st_nxt.pslverr = 1'b0;
			st_nxt.prdata = 32'h0;
			if (psel && penable && pwrite && !st_r.pslverr) begin
				if (idx == IDX_RAM_DATA) begin
					st_nxt.fm_we = 1'b1;
					st_nxt.fm_addr = ram_addr_counter;
					st_nxt.fm_wdata = pwdata[17:0];
					st_nxt.regs[IDX_RAM_ADDR] = {15'h0,
						ram_addr_counter + addr_step};
				end else begin
					for (int i = 0; i < REG_STORE; i++) begin
						if (idx == 6'(i)) begin
							st_nxt.regs[i] = pwdata & REG_MASK[i];
						end
					end
				end
			end
		end else if (psel && penable) begin
			st_nxt.pready = 1'b1;
			st_nxt.pslverr = refuse;
			st_nxt.prdata = pwrite ? 32'h0 : rdata;
		end

		if (srst) begin
			st_nxt = '0;
			// Frame memory is not touched here
			st_nxt.fm_we = 1'b0;
			for (int i = 0; i < REG_STORE; i++) begin
				st_nxt.regs[i] = REG_RST[i];
			end
			st_nxt.im = host_if_select;
			st_nxt.bus = dmr_decode(host_if_select);
			st_nxt.mode = MODE_INT;
			st_nxt.vs_q = rgb_vsync;
			st_nxt.dclk_q = rgb_dotclk;
		end
	end

	always_ff @(posedge mclk) begin
		st_r <= st_nxt;
	end

	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign fm_we = st_r.fm_we;
	assign fm_addr = st_r.fm_addr;
	assign fm_wdata = st_r.fm_wdata;
	assign host_bus_type = st_r.bus;
	assign host_bus_80 = st_r.im[1];
	assign disp_mode = st_r.mode;
	assign scan_line = st_r.scan_line;
	assign scan_frame_start = st_r.frame_start;
	assign osc_run = st_r.regs[IDX_OSC][F_OSC_RUN];
	assign osc_settled = st_r.settled;

	default clocking dmr_cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	AST_OSC_RST: assert property ($fell(srst) |-> osc_run)
		else $error("oscillator run not set by reset");
	AST_DRV_RST: assert property ($fell(srst) |->
		st_r.regs[IDX_DRV][15:0] == 16'h0027)
		else $error("driver output control reset value wrong");
	AST_AC_RST: assert property ($fell(srst) |->
		st_r.regs[IDX_AC][15:0] == 16'h0001)
		else $error("ac drive reset value wrong");
	AST_ENTRY_RST: assert property ($fell(srst) |->
		st_r.regs[IDX_ENTRY][15:0] == 16'h0030)
		else $error("entry mode reset value wrong");
	AST_DISP1_RST: assert property ($fell(srst) |->
		st_r.regs[IDX_DISP1] == 32'h0)
		else $error("display control reset value wrong");
	AST_PORCH_RST: assert property ($fell(srst) |->
		front_porch_lines == 4'h8 && back_porch_lines == 4'h8)
		else $error("porch reset value wrong");
	AST_FRAME_RST: assert property ($fell(srst) |->
		st_r.regs[IDX_FRAME] == 32'h0 && line_last == 5'h0f)
		else $error("frame cycle reset value wrong");
	AST_EXT_RST: assert property ($fell(srst) |->
		st_r.regs[IDX_EXT] == 32'h0 ##1 disp_mode == MODE_INT)
		else $error("external interface reset value wrong");
	AST_PWR_RST: assert property ($fell(srst) |->
		st_r.regs[IDX_PWR1] == 32'h30 && st_r.regs[IDX_PWR3] == 32'h0)
		else $error("power control reset value wrong");
	AST_ADDR_RST: assert property ($fell(srst) |->
		ram_addr_counter == 17'h00000)
		else $error("address counter not cleared by reset");
	AST_GAMMA_RST: assert property ($fell(srst) |->
		st_r.regs[IDX_GAMMA0] == 32'h0 && st_r.regs[IDX_SCROLL] == 32'h0)
		else $error("gamma or scroll reset value wrong");
	AST_SCR_RST: assert property ($fell(srst) |->
		st_r.regs[IDX_SCR1] == 32'h013f_0000
		&& st_r.regs[IDX_SCR2] == 32'h013f_0000)
		else $error("screen division reset value wrong");
	AST_WIN_RST: assert property ($fell(srst) |->
		st_r.regs[IDX_WIN_H] == 32'h01df_0000
		&& st_r.regs[IDX_WIN_V] == 32'h013f_0000)
		else $error("window reset value wrong");
	AST_NO_CLEAR: assert property ($fell(srst) |-> !fm_we [*2])
		else $error("frame memory written after reset");
	AST_SYS_ONLY: assert property (pready && !pslverr && pwrite
		&& idx == IDX_RAM_DATA && psel && penable |=> fm_we
		&& fm_wdata == $past(pwdata[17:0]))
		else $error("system bus memory write lost");
	AST_RGB_REFUSE: assert property (psel && penable && !pready
		&& pwrite && idx == IDX_RAM_DATA && ram_write_path |=> pslverr)
		else $error("memory write on system bus not refused in RGB path");
	// Mode is registered, so it lags its fields by one clock
	AST_EXCL: assert property (disp_mode == MODE_RGB
		|-> $past(display_timing_src) == 2'b01 && $past(ram_write_path))
		else $error("RGB mode without both selections");
	AST_PIX: assert property (pix_take && !vs_active_edge |=> fm_we
		&& fm_wdata == $past(rgb_data))
		else $error("pixel not captured");
	AST_PIX_EN: assert property (fm_we && disp_mode == MODE_RGB
		|-> $past(rgb_enable) != enable_polarity)
		else $error("pixel captured without data enable");
	AST_FSYNC: assert property (disp_mode == MODE_FSYNC && vs_fall
		|=> scan_line == 10'h000 && scan_frame_start)
		else $error("scan not restarted by frame sync");
	AST_DECODE: assert property ($fell(srst) |->
		host_bus_type == dmr_decode($past(host_if_select)))
		else $error("host bus decode wrong");
	AST_OFF_REFUSE: assert property (psel && penable && !pready
		&& pwrite && host_bus_type == BUS_OFF |=> pslverr)
		else $error("register write accepted with host bus disabled");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	AST_INT_MODE: assert property (disp_mode == MODE_INT
		|-> $past(display_timing_src) == 2'b00 && !$past(ram_write_path))
		else $error("internal clock mode without its selection");
	AST_FSYNC_MODE: assert property (disp_mode == MODE_FSYNC
		|-> $past(display_timing_src) == 2'b10 && !$past(ram_write_path))
		else $error("frame sync mode without its selection");
	AST_BAD_STOP: assert property (disp_mode == MODE_BAD
		|=> $stable(scan_line))
		else $error("scan advanced in inconsistent mode");
	AST_FRAME_ZERO: assert property (scan_frame_start
		|-> scan_line == 10'h000)
		else $error("frame start away from line zero");

	COV_PIX: cover property (pix_take ##1 fm_we);
	COV_SYS_WR: cover property (fm_we && disp_mode == MODE_INT);
	COV_FSYNC: cover property (disp_mode == MODE_FSYNC && vs_fall);
	COV_REFUSE: cover property (pready && pslverr);
	COV_RGB_MODE: cover property (disp_mode == MODE_RGB);
endmodule

//--- verification/dmr_host.sv
/*
 * Host processor model: drives the APB register bus and the static
 * host bus mode pins of the display mode block.
 * Assumes mclk from the bench and one transfer at a time.
 */
module dmr_host (
	input wire logic mclk, // System clock
	input wire logic pready, // Slave ready
	input wire logic pslverr, // Slave error
	input wire logic [31:0] prdata, // Read data
	output logic psel, // Select
	output logic penable, // Enable
	output logic pwrite, // Direction
	output logic [7:0] paddr, // Byte address
	output logic [31:0] pwdata, // Write data
	output logic [3:0] host_if_select // Mode pins
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		host_if_select = 4'h0;
	end

	// Pins only move while the bench holds reset
	task set_pins(input logic [3:0] p);
		host_if_select <= p;
	endtask

	// Request held until pready is seen at a rising edge or 20 edges pass
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err, output logic ok);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		ok = 1'b0;
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge mclk);
			ok = (pready === 1'b1);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

//--- verification/dmr_top_tb.sv
/*
 * Self-checking bench of the display mode block: reset defaults, host bus
 * decode, mode decode, both frame memory write paths and refusals.
 * Assumes the host model drives APB; the bench drives the pixel port.
 */
module dmr_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dmr_pkg::*;

	localparam int SETTLE = 20;
	localparam logic [31:0] EV [7] = '{32'h000, 32'h110, 32'h020, 32'h010,
		32'h120, 32'h100, 32'h030};
	localparam dmr_mode_t EM [7] = '{MODE_INT, MODE_RGB, MODE_FSYNC,
		MODE_BAD, MODE_BAD, MODE_BAD, MODE_BAD};

	logic mclk, srst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pins;
	logic rgb_vsync, rgb_dotclk, rgb_enable, fm_we, host_bus_80;
	logic [17:0] rgb_data, fm_wdata;
	logic [16:0] fm_addr;
	dmr_bus_t host_bus_type;
	dmr_mode_t disp_mode;
	logic [9:0] scan_line;
	logic scan_frame_start, osc_run, osc_settled, err, ok;
	int n_fail, check_count;

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	dmr_top #(.SETTLE_CYCLES(SETTLE)) dut (.mclk(mclk), .srst(srst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .host_if_select(pins), .rgb_vsync(rgb_vsync),
		.rgb_dotclk(rgb_dotclk), .rgb_enable(rgb_enable),
		.rgb_data(rgb_data), .fm_we(fm_we), .fm_addr(fm_addr),
		.fm_wdata(fm_wdata), .host_bus_type(host_bus_type),
		.host_bus_80(host_bus_80), .disp_mode(disp_mode),
		.scan_line(scan_line), .scan_frame_start(scan_frame_start),
		.osc_run(osc_run), .osc_settled(osc_settled));

	dmr_host host (.mclk(mclk), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .host_if_select(pins));

	task give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task chk(input string what, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		host.xfer(w, a, d, rd, err, ok);
		chk("pready", 32'h1, {31'h0, ok});
		if (!ok) begin
			give_verdict();
		end
	endtask

	task wr(input logic [5:0] idx, input logic [31:0] d);
		apb(1'b1, {idx, 2'b00}, d);
		chk("pslverr", 32'h0, {31'h0, err});
	endtask

	task rdchk(input logic [5:0] idx, input logic [31:0] e);
		apb(1'b0, {idx, 2'b00}, 32'h0);
		chk("read data", e, rd);
	endtask

	task do_reset(input logic [3:0] p);
		int n;
		host.set_pins(p);
		srst <= 1'b1;
		repeat (6) @(posedge mclk);
		srst <= 1'b0;
		@(negedge mclk);
		chk("osc_run", 32'h1, {31'h0, osc_run});
		for (n = 0; n < SETTLE + 10 && osc_settled !== 1'b1; n++) begin
			@(negedge mclk);
		end
		chk("settle", 32'h1, {31'h0, n >= SETTLE - 2 && osc_settled});
	endtask

	task wait_we(input logic [16:0] a, input logic [17:0] d);
		int n;
		for (n = 0; n < 4 && fm_we !== 1'b1; n++) begin
			@(negedge mclk);
		end
		chk("fm_we", 32'h1, {31'h0, fm_we});
		chk("fm_addr", {15'h0, a}, {15'h0, fm_addr});
		chk("fm_wdata", {14'h0, d}, {14'h0, fm_wdata});
		@(negedge mclk);
		chk("fm_we pulse", 32'h0, {31'h0, fm_we});
	endtask

	task no_we();
		repeat (4) begin
			@(negedge mclk);
			chk("fm_we idle", 32'h0, {31'h0, fm_we});
		end
	endtask

	task pixel(input logic en, input logic [17:0] d);
		@(posedge mclk);
		rgb_enable <= en;
		rgb_data <= d;
		rgb_dotclk <= 1'b1;
		@(posedge mclk);
		rgb_dotclk <= 1'b0;
		rgb_enable <= 1'b0;
		rgb_data <= ~d;
	endtask

	function automatic dmr_bus_t exp_bus(input logic [3:0] p);
		casez (p)
			4'b00?0: return BUS_P16;
			4'b00?1: return BUS_P8;
			4'b010?: return BUS_SPI;
			4'b10?0: return BUS_P18;
			4'b10?1: return BUS_P9;
			4'b110?: return BUS_PKT;
			default: return BUS_OFF;
		endcase
	endfunction

	task t_defaults();
		chk("disp_mode", {30'h0, MODE_INT}, {30'h0, disp_mode});
		for (int i = 0; i < REG_STORE; i++) begin
			rdchk(i[5:0], REG_RST[i]);
		end
		wr(IDX_DRV, 32'hffff_ffff);
		rdchk(IDX_DRV, REG_MASK[1]);
		$display("test defaults done");
	endtask

	task t_bus();
		dmr_bus_t b;
		for (int p = 0; p < 16; p++) begin
			do_reset(p[3:0]);
			b = exp_bus(p[3:0]);
			chk("bus type", {29'h0, b}, {29'h0, host_bus_type});
			chk("bus 80", {31'h0, p[1]}, {31'h0, host_bus_80});
			apb(1'b0, {IDX_STATUS, 2'b00}, 32'h0);
			chk("status", {25'h0, b, p[3:0]}, {25'h0, rd[6:0]});
			apb(1'b1, {IDX_DISP2, 2'b00}, 32'h0);
			chk("off refusal", {31'h0, b == BUS_OFF}, {31'h0, err});
		end
		$display("test bus decode done");
	endtask

	task t_sys();
		do_reset(4'h0);
		wr(IDX_RAM_DATA, 32'h2aaaa);
		wait_we(17'h0, 18'h2aaaa);
		wr(IDX_RAM_DATA, 32'h15555);
		wait_we(17'h1, 18'h15555);
		$display("test system path done");
	endtask

	task t_rgb();
		do_reset(4'h0);
		wr(IDX_RAM_ADDR, 32'h5);
		wr(IDX_EXT, 32'h110);
		repeat (2) @(negedge mclk);
		chk("disp_mode", {30'h0, MODE_RGB}, {30'h0, disp_mode});
		apb(1'b1, {IDX_RAM_DATA, 2'b00}, 32'h1);
		chk("ram path refusal", 32'h1, {31'h0, err});
		no_we();
		pixel(1'b1, 18'h2a5a5);
		wait_we(17'h5, 18'h2a5a5);
		pixel(1'b0, 18'h11111);
		no_we();
		pixel(1'b1, 18'h00f0f);
		wait_we(17'h6, 18'h00f0f);
		rdchk(IDX_DRV, REG_RST[1]);
		$display("test rgb path done");
	endtask

	task t_fsync();
		logic seen;
		do_reset(4'h0);
		wr(IDX_WIN_H, 32'h01df_0012);
		wr(IDX_WIN_V, 32'h013f_0034);
		wr(IDX_RAM_ADDR, 32'h100);
		wr(IDX_EXT, 32'h020);
		@(posedge mclk);
		rgb_vsync <= 1'b0;
		seen = 1'b0;
		for (int n = 0; n < 6 && !seen; n++) begin
			@(negedge mclk);
			seen = (scan_frame_start === 1'b1);
		end
		chk("sync restart", 32'h1, {31'h0, seen});
		chk("scan_line", 32'h0, {22'h0, scan_line});
		repeat (15) @(negedge mclk);
		chk("line period", 32'h0, {22'h0, scan_line});
		@(negedge mclk);
		chk("line period", 32'h1, {22'h0, scan_line});
		@(posedge mclk);
		rgb_vsync <= 1'b1;
		wr(IDX_RAM_DATA, 32'h01234);
		wait_we({9'h034, 8'h12}, 18'h01234);
		$display("test frame sync done");
	endtask

	task t_modes();
		do_reset(4'h0);
		for (int k = 0; k < 7; k++) begin
			wr(IDX_EXT, EV[k]);
			apb(1'b0, {IDX_STATUS, 2'b00}, 32'h0);
			chk("mode", {30'h0, EM[k]}, {30'h0, disp_mode});
			chk("excl", {30'h0, EM[k] == MODE_FSYNC, EM[k] == MODE_RGB},
				{30'h0, rd[9:8]});
		end
		$display("test mode decode done");
	endtask

	task t_errs();
		apb(1'b0, 8'h02, 32'h0);
		chk("misaligned", 32'h1, {31'h0, err});
		apb(1'b0, 8'h64, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		apb(1'b1, {IDX_STATUS, 2'b00}, 32'h0);
		chk("status write", 32'h1, {31'h0, err});
		$display("test refusals done");
	endtask

	initial begin
		n_fail = 0;
		check_count = 0;
		srst = 1'b1;
		rgb_vsync = 1'b1;
		rgb_dotclk = 1'b0;
		rgb_enable = 1'b0;
		rgb_data = 18'h0;
		do_reset(4'h0);
		t_defaults();
		t_bus();
		t_sys();
		t_rgb();
		t_fsync();
		t_modes();
		t_errs();
		give_verdict();
	end

	initial begin
		repeat (50000) @(posedge mclk);
		n_fail++;
		give_verdict();
	end
endmodule
